// File: hdl/pcl_pkg.sv
/*
 Package for the PWM current-limit input logic: register offsets, field
 positions, reset values and carrier structs.
 Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package pcl_pkg;
   localparam int NUM_SRC = 32;
   localparam int SEL_W = 5;
   // Register byte offsets
   localparam logic [7:0] OFF_FCL = 8'h00;
   localparam logic [7:0] OFF_PWMCON = 8'h04;
   localparam logic [7:0] OFF_IOCON = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_PINS = 8'h14;
   localparam logic [7:0] OFF_MOD = 8'h18;
   // Fault/current-limit control fields
   localparam int FCL_CLSEL_LO = 10;
   localparam int FCL_CL_POLARITY = 9;
   localparam int FCL_CLOVR = 8;
   localparam int FCL_FSEL_LO = 3;
   localparam int FCL_FPOL = 2;
   localparam int FCL_FMODE_LO = 0;
   localparam int FCL_INDEP = 15;
   // PWM control fields
   localparam int PC_CL_STATUS = 14;
   localparam int PC_FSTAT = 15;
   localparam int PC_FIEN = 12;
   localparam int PC_CL_IRQ_EN = 11;
   localparam int PC_XRES = 1;
   localparam int PC_ITB = 9;
   // I/O control fields
   localparam int IO_FDAT_LO = 4;
   localparam int IO_CL_OVERRIDE_DATA_LO = 2;
   // Status / mask bits
   localparam int EV_CL = 0;
   localparam int EV_FLT = 1;
   localparam int EV_TBR = 2;
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   localparam logic [1:0] FMODE_OFF = 2'h3;

   // Decoded configuration carried to the datapath
   typedef struct packed {
      logic [4:0] cl_sel;
      logic [4:0] flt_sel;
      logic cl_pol;
      logic flt_pol;
      logic cl_ovr_en;
      logic flt_ovr_en;
      logic indep;
      logic ext_tb_rst_en;
      logic independent_timebase_mode;
      logic [1:0] cl_data;
      logic [1:0] flt_data;
   } pcl_cfg_t;

   // High/low output pair
   typedef struct packed {
      logic hi;
      logic lo;
   } pcl_pair_t;
endpackage

// File: hdl/pcl_sync.sv
/*
 Three-stage synchroniser bank with agreement filter.
 Assumes asynchronous inputs; output changes once stages two and three agree.
*/
`timescale 1ns/1ns
module pcl_sync #(
   parameter int W = 32
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   // Shift chain; first stage read only by the second
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a bit only when stages two and three agree
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               out_q[g] <= 1'b0;
            end else if (s2_q[g] == s3_q[g]) begin
               out_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate

   assign o_sync = out_q;
endmodule

// File: hdl/pcl_top.sv
/*
 PWM current-limit input logic for one generator: source muxes, polarity,
 override priority, interrupt and status, current-reset mode, ADC triggers.
 Assumes APB master on i_mclk, sources asynchronous, PWM and dead-time
 path and time base outside the block.
*/
`timescale 1ns/1ns
module pcl_top #(
   parameter int NSRC = pcl_pkg::NUM_SRC
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [NSRC-1:0] i_src,
   input wire logic i_other_cl_irq,
   input wire pcl_pkg::pcl_pair_t i_pwm,
   input wire pcl_pkg::pcl_pair_t i_dt_pwm,
   input wire logic i_tb_zero,
   output pcl_pkg::pcl_pair_t o_pwm,
   output pcl_pkg::pcl_pair_t o_ovr_dt_data,
   output logic o_ovr_dt_sel,
   output logic o_dt_comp,
   output logic o_tb_reset,
   output logic o_adc_trig_cl,
   output logic o_adc_trig_flt,
   output logic o_cl_irq_line,
   output logic o_irq
);
   import pcl_pkg::*;

   logic [31:0] fcl_q;
   logic [31:0] pc_q;
   logic [31:0] io_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;
   logic mod_en_q;
   logic cl_flag_q;
   logic flt_flag_q;
   logic cl_prev_q;
   logic flt_prev_q;
   logic flt_hold_q;
   logic [NSRC-1:0] src_s;
   pcl_cfg_t cfg;
   logic cl_raw;
   logic flt_raw;
   logic cl_act;
   logic flt_act;
   logic cl_rise;
   logic flt_rise;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [31:0] rd_d;
   logic cl_ovr;
   logic flt_ovr;
   logic tb_rst_d;
   logic cl_evt;
   logic flt_evt;
   logic wr_fcl;
   logic wr_pc;
   logic wr_io;
   logic wr_stat;
   logic wr_mask;
   logic wr_mod;
   logic [2:0] stat_set;
   logic [31:0] pins_rd;

   // Mux one source by a select field
   function automatic logic pick(input logic [NSRC-1:0] v,
                                 input logic [SEL_W-1:0] s);
      pick = v[s];
   endfunction

   // Address decode used only for the slave error response
   function automatic logic hit(input logic [7:0] a);
      hit = (a == OFF_FCL) || (a == OFF_PWMCON) || (a == OFF_IOCON) ||
            (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) ||
            (a == OFF_PINS) || (a == OFF_MOD);
   endfunction

   // Source inputs cross into i_mclk
   pcl_sync #(.W(NSRC)) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async(i_src),
      .o_sync(src_s)
   );

   // Configuration fields
   always_comb begin
      cfg.cl_sel = fcl_q[FCL_CLSEL_LO +: SEL_W];
      cfg.flt_sel = fcl_q[FCL_FSEL_LO +: SEL_W];
      cfg.cl_pol = fcl_q[FCL_CL_POLARITY];
      cfg.flt_pol = fcl_q[FCL_FPOL];
      cfg.cl_ovr_en = fcl_q[FCL_CLOVR];
      cfg.flt_ovr_en = fcl_q[FCL_FMODE_LO +: 2] != FMODE_OFF;
      cfg.indep = fcl_q[FCL_INDEP];
      cfg.ext_tb_rst_en = pc_q[PC_XRES];
      cfg.independent_timebase_mode = pc_q[PC_ITB];
      cfg.cl_data = io_q[IO_CL_OVERRIDE_DATA_LO +: 2];
      cfg.flt_data = io_q[IO_FDAT_LO +: 2];
   end

   // Source muxes and polarity, ahead of every consumer
   assign cl_raw = pick(src_s, cfg.cl_sel);
   assign flt_raw = pick(src_s, cfg.flt_sel);
   assign cl_act = cl_raw ^ cfg.cl_pol;
   assign flt_act = flt_raw ^ cfg.flt_pol;
   assign cl_rise = cl_act & ~cl_prev_q;
   assign flt_rise = flt_act & ~flt_prev_q;

   // Shared consumers of the adjusted signals
   assign o_dt_comp = cl_act;
   assign o_adc_trig_cl = cl_act;
   assign o_adc_trig_flt = flt_act;

   // Edge history
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cl_prev_q <= 1'b0;
         flt_prev_q <= 1'b0;
      end else begin
         cl_prev_q <= cl_act;
         flt_prev_q <= flt_act;
      end
   end

   // Fault hold until cycle boundary after the fault clears
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         flt_hold_q <= 1'b0;
      end else if (flt_act && cfg.flt_ovr_en) begin
         flt_hold_q <= 1'b1;
      end else if (i_tb_zero || !mod_en_q) begin
         flt_hold_q <= 1'b0;
      end
   end

   // Override priority: fault first, then current limit
   assign flt_ovr = cfg.flt_ovr_en && (flt_act || flt_hold_q);
   assign cl_ovr = cfg.cl_ovr_en && cl_act &&
                   !cfg.indep;

   // Output path: zero data forced directly, one data via dead time
   always_comb begin
      o_ovr_dt_sel = 1'b0;
      o_ovr_dt_data = '0;
      o_pwm = i_pwm;
      if (flt_ovr) begin
         o_ovr_dt_sel = 1'b1;
         o_ovr_dt_data = cfg.flt_data;
         o_pwm.hi = cfg.flt_data[1] & i_dt_pwm.hi;
         o_pwm.lo = cfg.flt_data[0] & i_dt_pwm.lo;
      end else if (cl_ovr) begin
         o_ovr_dt_sel = 1'b1;
         o_ovr_dt_data = cfg.cl_data;
         o_pwm.hi = cfg.cl_data[1] & i_dt_pwm.hi;
         o_pwm.lo = cfg.cl_data[0] & i_dt_pwm.lo;
      end
   end

   // Current-reset mode
   assign tb_rst_d = cl_rise && !cfg.cl_ovr_en && cfg.ext_tb_rst_en &&
                     cfg.independent_timebase_mode;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_tb_reset <= 1'b0;
      end else begin
         o_tb_reset <= tb_rst_d;
      end
   end

   // APB access strobes; zero wait states
   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign mapped = hit(i_paddr);
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;

   // Per-register write strobes, access phase only
   assign wr_fcl = wr_en && (i_paddr == OFF_FCL);
   assign wr_pc = wr_en && (i_paddr == OFF_PWMCON);
   assign wr_io = wr_en && (i_paddr == OFF_IOCON);
   assign wr_stat = wr_en && (i_paddr == OFF_IRQ_STAT);
   assign wr_mask = wr_en && (i_paddr == OFF_IRQ_MASK);
   assign wr_mod = wr_en && (i_paddr == OFF_MOD);

   // Fault/current-limit control; upper half reserved
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         fcl_q <= RST_VAL;
      end else if (wr_fcl) begin
         fcl_q <= i_pwdata & 32'h0000_ffff;
      end
   end

   // PWM control; status bits are built on read, not stored
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pc_q <= RST_VAL;
      end else if (wr_pc) begin
         pc_q <= i_pwdata & 32'h0000_1a02;
      end
   end

   // I/O control; only the two override data pairs are kept
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         io_q <= RST_VAL;
      end else if (wr_io) begin
         io_q <= i_pwdata & 32'h0000_003c;
      end
   end

   // Interrupt mask, same layout as status
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mask_q <= '0;
      end else if (wr_mask) begin
         mask_q <= i_pwdata[2:0];
      end
   end

   // Module enable; gates pin readback and fault hold
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mod_en_q <= 1'b0;
      end else if (wr_mod) begin
         mod_en_q <= i_pwdata[0];
      end
   end

   // Events, each gated by its interrupt enable
   assign cl_evt = cl_rise && pc_q[PC_CL_IRQ_EN];
   assign flt_evt = flt_rise && pc_q[PC_FIEN];

   // Event bits placed at their status positions
   always_comb begin
      stat_set = '0;
      stat_set[EV_CL] = cl_evt;
      stat_set[EV_FLT] = flt_evt;
      stat_set[EV_TBR] = tb_rst_d;
   end

   // Current-limit flag: set wins, cleared by dropping enable
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cl_flag_q <= 1'b0;
      end else if (cl_evt) begin
         cl_flag_q <= 1'b1;
      end else if (!pc_q[PC_CL_IRQ_EN]) begin
         cl_flag_q <= 1'b0;
      end
   end

   // Fault flag, same scheme
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         flt_flag_q <= 1'b0;
      end else if (flt_evt) begin
         flt_flag_q <= 1'b1;
      end else if (!pc_q[PC_FIEN]) begin
         flt_flag_q <= 1'b0;
      end
   end

   // Sticky event status, write one to clear, set wins
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         stat_q <= '0;
      end else if (wr_stat) begin
         stat_q <= (stat_q & ~i_pwdata[2:0]) | stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end

   // Pin readback word, one bit per source
   assign pins_rd = 32'(src_s);

   // Interrupt lines
   assign o_cl_irq_line = cl_flag_q | i_other_cl_irq;
   assign o_irq = |(stat_q & mask_q);

   // Read mux
   always_comb begin
      rd_d = '0;
      unique case (i_paddr)
         OFF_FCL: rd_d = fcl_q;
         OFF_PWMCON: begin
            rd_d = pc_q;
            rd_d[PC_CL_STATUS] = pc_q[PC_CL_IRQ_EN] ? cl_flag_q : cl_act;
            rd_d[PC_FSTAT] = pc_q[PC_FIEN] ? flt_flag_q : flt_act;
         end
         OFF_IOCON: rd_d = io_q;
         OFF_IRQ_STAT: rd_d = {29'h0, stat_q};
         OFF_IRQ_MASK: rd_d = {29'h0, mask_q};
         OFF_PINS: rd_d = mod_en_q ? pins_rd : 32'h0;
         OFF_MOD: rd_d = {31'h0, mod_en_q};
         default: rd_d = '0;
      endcase
   end

   // Read data register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata <= '0;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= rd_d;
      end
   end
endmodule

// File: tb/pcl_properties.sv
/*
 Port checker for pcl_top, attached by bind.
 Assumes one clock i_mclk and asynchronous active-high i_rst.
*/
`timescale 1ns/1ns
module pcl_properties (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic i_other_cl_irq,
   input wire pcl_pkg::pcl_pair_t i_pwm,
   input wire pcl_pkg::pcl_pair_t i_dt_pwm,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire pcl_pkg::pcl_pair_t o_pwm,
   input wire pcl_pkg::pcl_pair_t o_ovr_dt_data,
   input wire logic o_ovr_dt_sel,
   input wire logic o_dt_comp,
   input wire logic o_tb_reset,
   input wire logic o_adc_trig_cl,
   input wire logic o_cl_irq_line,
   input wire logic o_irq
);
   import pcl_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // Bus phases and the adjusted input edge
   sequence s_access; i_psel && i_penable; endsequence
   sequence s_cl_rise; !o_adc_trig_cl ##1 o_adc_trig_cl; endsequence
   pready_zero_wait_a: assert property (s_access |-> o_pready)
      else $error("pready low in access phase");
   slverr_phase_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("pslverr outside access phase");
   prdata_hold_a: assert property (!(i_psel && !i_penable && !i_pwrite)
      |=> $stable(o_prdata)) else $error("read data moved");
   trig_comp_a: assert property (o_adc_trig_cl == o_dt_comp)
      else $error("trigger and compensation differ");
   irq_or_a: assert property (i_other_cl_irq |-> o_cl_irq_line)
      else $error("other request not ored in");
   tbr_pulse_a: assert property (o_tb_reset |=> !o_tb_reset)
      else $error("time base reset longer than a cycle");
   tbr_cause_a: assert property (o_tb_reset |->
      $past(o_adc_trig_cl) && !$past(o_adc_trig_cl, 2))
      else $error("reset without rise");
   ovr_data_a: assert property (o_ovr_dt_sel |-> o_pwm ==
      {o_ovr_dt_data.hi & i_dt_pwm.hi, o_ovr_dt_data.lo & i_dt_pwm.lo})
      else $error("override output wrong");
   pwm_pass_a: assert property (!o_ovr_dt_sel |-> o_pwm == i_pwm)
      else $error("pwm altered without override");
   rst_quiet_a: assert property ($past(i_rst) |-> !o_irq && !o_tb_reset)
      else $error("output active after reset");
   cl_rise_c: cover property (s_cl_rise);
endmodule

bind pcl_top pcl_properties u_props (
   .i_mclk(i_mclk),
   .i_rst(i_rst),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .i_pwrite(i_pwrite),
   .i_other_cl_irq(i_other_cl_irq),
   .i_pwm(i_pwm),
   .i_dt_pwm(i_dt_pwm),
   .o_prdata(o_prdata),
   .o_pready(o_pready),
   .o_pslverr(o_pslverr),
   .o_pwm(o_pwm),
   .o_ovr_dt_data(o_ovr_dt_data),
   .o_ovr_dt_sel(o_ovr_dt_sel),
   .o_dt_comp(o_dt_comp),
   .o_tb_reset(o_tb_reset),
   .o_adc_trig_cl(o_adc_trig_cl),
   .o_cl_irq_line(o_cl_irq_line),
   .o_irq(o_irq)
);

// File: tb/pcl_src_model.sv
/*
 Current-sense source model: comparator and pin levels.
 Assumes the bench sets the wanted levels; pins move off the clock.
*/
`timescale 1ns/1ns
module pcl_src_model (
   input wire logic [31:0] i_want,
   output logic [31:0] o_src
);
   // Sources settle a few ns late, unrelated to the clock
   initial o_src = 32'h0;
   always @(i_want) o_src <= #3 i_want;
endmodule

// File: tb/pcl_top_bench.sv
/*
 Self-checking bench for pcl_top: random source and override traffic,
 fault priority, interrupts and current-reset mode.
 Assumes the APB slave answers in the access phase.
*/
`timescale 1ns/1ns
module pcl_top_bench;
   import pcl_pkg::*;
   logic i_mclk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic i_other_cl_irq = 0, i_tb_zero = 0, o_pready, o_pslverr, sl;
   logic o_ovr_dt_sel, o_dt_comp, o_tb_reset, o_adc_trig_cl, o_irq;
   logic o_adc_trig_flt, o_cl_irq_line;
   logic [7:0] i_paddr = 0;
   logic [31:0] i_pwdata = 0, o_prdata, i_src, rd, want = 0, rs;
   pcl_pair_t i_pwm = '0, i_dt_pwm = '0, o_pwm, o_ovr_dt_data;
   int n_fail = 0, checked = 0;
   always #4 i_mclk = ~i_mclk;
   pcl_src_model PM (.i_want(want), .o_src(i_src));
   pcl_top DUT (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .i_src(i_src),
      .i_other_cl_irq(i_other_cl_irq),
      .i_pwm(i_pwm),
      .i_dt_pwm(i_dt_pwm),
      .i_tb_zero(i_tb_zero),
      .o_pwm(o_pwm),
      .o_ovr_dt_data(o_ovr_dt_data),
      .o_ovr_dt_sel(o_ovr_dt_sel),
      .o_dt_comp(o_dt_comp),
      .o_tb_reset(o_tb_reset),
      .o_adc_trig_cl(o_adc_trig_cl),
      .o_adc_trig_flt(o_adc_trig_flt),
      .o_cl_irq_line(o_cl_irq_line),
      .o_irq(o_irq)
   );
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] fcl(input logic [4:0] cs, fs,
      input logic cp, fp, ov, ind, input logic [1:0] fm);
      return {16'h0, ind, cs, cp, ov, fs, fp, fm};
   endfunction
   function automatic pcl_pair_t epwm(input logic [1:0] d, input logic on,
      input pcl_pair_t p, q);
      return on ? pcl_pair_t'({d[1] & q.hi, d[0] & q.lo}) : p;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (o_pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         summarize();
      end
      rd = o_prdata;
      sl = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [4:0] cs, fs;
      logic cp, fp, ov, c;
      int n;
      rs = 32'h610830a7;
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         apb(0, 8'(i * 4), 0);
         chk(rd, RST_VAL);
      end
      apb(0, 8'h40, 0);
      chk({rd[0], sl}, 2'b01);
      // Random source, polarity and override traffic
      for (int i = 0; i < 24; i++) begin
         rs = xs(rs);
         r = rs;
         {cs, fs, cp, fp, ov} = r[12:0];
         apb(1, OFF_FCL, fcl(cs, fs, cp, fp, ov, 1'b0, FMODE_OFF));
         apb(1, OFF_IOCON, {28'h0, r[14:13], 2'b0});
         rs = xs(rs);
         want <= rs;
         {i_pwm, i_dt_pwm} <= r[18:15];
         repeat (6) @(posedge i_mclk);
         c = rs[cs] ^ cp;
         chk(o_adc_trig_cl, c);
         chk(o_dt_comp, c);
         chk(o_adc_trig_flt, rs[fs] ^ fp);
         chk(o_pwm, epwm(r[14:13], ov & c, r[18:17], r[16:15]));
         chk({o_ovr_dt_sel, o_ovr_dt_data},
             {ov & c, (ov & c) ? r[14:13] : 2'b00});
         apb(0, OFF_PWMCON, 0);
         chk(rd[PC_CL_STATUS], c);
      end
      // Fault wins, then holds until the time base wraps
      apb(1, OFF_MOD, 1);
      apb(1, OFF_IOCON, 32'h38);
      apb(1, OFF_FCL, fcl(1, 2, 0, 0, 1, 0, 2'h1));
      {i_pwm, i_dt_pwm} <= 4'h3;
      want <= 32'h6;
      repeat (6) @(posedge i_mclk);
      chk(o_pwm, 2'b11);
      want <= 32'h2;
      repeat (6) @(posedge i_mclk);
      chk(o_pwm, 2'b11);
      i_tb_zero <= 1'b1;
      @(posedge i_mclk);
      i_tb_zero <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk(o_pwm, 2'b10);
      apb(0, OFF_PINS, 0);
      chk(rd, 32'h2);
      apb(1, OFF_IOCON, 32'h30);
      apb(1, OFF_FCL, fcl(1, 2, 0, 0, 1, 1, 2'h1));
      {i_pwm, i_dt_pwm} <= 4'hf;
      repeat (2) @(posedge i_mclk);
      chk(o_pwm, 2'b11);
      // Interrupt raised, masked, cleared
      apb(1, OFF_FCL, fcl(0, 2, 0, 0, 0, 0, FMODE_OFF));
      apb(1, OFF_PWMCON, 32'h800);
      want <= 32'h1;
      repeat (6) @(posedge i_mclk);
      chk(o_irq, 0);
      chk(o_cl_irq_line, 1);
      apb(1, OFF_IRQ_MASK, 1);
      want <= 32'h0;
      repeat (6) @(posedge i_mclk);
      chk(o_irq, 1);
      apb(0, OFF_PWMCON, 0);
      chk(rd[PC_CL_STATUS], 1);
      apb(0, OFF_IRQ_STAT, 0);
      chk(rd[EV_CL], 1);
      apb(1, OFF_IRQ_STAT, 1);
      @(posedge i_mclk);
      chk(o_irq, 0);
      apb(1, OFF_PWMCON, 0);
      repeat (2) @(posedge i_mclk);
      chk(o_cl_irq_line, 0);
      i_other_cl_irq <= 1'b1;
      repeat (2) @(posedge i_mclk);
      chk(o_cl_irq_line, 1);
      i_other_cl_irq <= 1'b0;
      // Current-reset mode on and off
      for (int j = 0; j < 2; j++) begin
         apb(1, OFF_PWMCON, j ? 32'h200 : 32'h202);
         want <= 32'h1;
         n = 0;
         repeat (8) begin
            @(posedge i_mclk);
            n += o_tb_reset;
         end
         chk(n, j ? 0 : 1);
         want <= 32'h0;
         repeat (6) @(posedge i_mclk);
      end
      apb(0, OFF_IRQ_STAT, 0);
      chk(rd[EV_TBR], 1);
      summarize();
   end
endmodule
